// ---- rtl/sfwp_core.sv ----
// serial flash command framing and write protection
// link pins are asynchronous; ref_clk oversamples sclk
`timescale 1ns/1ps
module sfwp_core
  import sfwp_pkg::*;
#(
  parameter logic [7:0] MFR_ID  = MFR_ID_DEF,  // arbitrary value
  parameter logic [7:0] TYPE_ID = TYPE_ID_DEF, // arbitrary value
  parameter logic [7:0] CAP_ID  = CAP_ID_DEF   // arbitrary value
)(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        power_up,
  input  wire logic        sclk,
  input  wire logic        cs_b,
  input  wire logic        si,
  input  wire logic        wp_b,
  output logic             so,
  output logic             so_oe,
  output logic [7:0]       status1,
  output logic [7:0]       status2,
  output logic             deep_power_down,
  output sfwp_cmd_t        exec_cmd,
  output logic             exec_blocked
);

  logic [2:0] sclk_sync_reg, sclk_sync_next;
  logic [1:0] cs_sync_reg, cs_sync_next;
  logic [1:0] si_sync_reg, si_sync_next;
  logic [1:0] wp_sync_reg, wp_sync_next;
  logic       cs_q_reg, cs_q_next;

  always_comb begin
    sclk_sync_next = {sclk_sync_reg[1:0], sclk};
    cs_sync_next   = {cs_sync_reg[0], cs_b};
    si_sync_next   = {si_sync_reg[0], si};
    wp_sync_next   = {wp_sync_reg[0], wp_b};
    cs_q_next      = cs_sync_reg[1];
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 2'h3;
      si_sync_reg   <= 2'h0;
      wp_sync_reg   <= 2'h3;
      cs_q_reg      <= 1'b1;
    end else begin
      sclk_sync_reg <= sclk_sync_next;
      cs_sync_reg   <= cs_sync_next;
      si_sync_reg   <= si_sync_next;
      wp_sync_reg   <= wp_sync_next;
      cs_q_reg      <= cs_q_next;
    end
  end

  logic cs_low, cs_rise, sclk_rise, sclk_fall, wp_n;
  assign cs_low    = !cs_sync_reg[1];
  assign cs_rise   = cs_sync_reg[1] && !cs_q_reg;
  assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  assign sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2];
  assign wp_n      = wp_sync_reg[1];

  // frame state
  logic [2:0]  bit_reg, bit_next;
  logic [8:0]  byte_reg, byte_next;
  logic [7:0]  sh_reg, sh_next;
  logic [7:0]  op_reg, op_next;
  logic [23:0] addr_reg, addr_next;
  logic [7:0]  d1_reg, d1_next;
  logic [7:0]  d2_reg, d2_next;
  logic [7:0]  out_reg, out_next;
  logic        so_reg, so_next;
  logic        oe_reg, oe_next;
  // status state
  logic        wel_reg, wel_next;
  logic        lklo_reg, lklo_next;
  logic        lkhi_reg, lkhi_next;
  logic        inv_reg, inv_next;
  logic        sec_reg, sec_next;
  logic        tb_reg, tb_next;
  logic [2:0]  bp_reg, bp_next;
  logic [2:0]  lb_reg, lb_next;
  logic        qe_reg, qe_next;
  sfwp_pwr_t   pwr_reg, pwr_next;
  sfwp_cmd_t   cmd_reg, cmd_next;
  logic        blk_reg, blk_next;

  sfwp_prot_cfg_t cfg;
  logic           prot_hit;
  assign cfg = '{invert_protect_map: inv_reg, small_unit_select: sec_reg,
                 bottom_up_select: tb_reg, protect_size: bp_reg};

  // range decode on the captured address
  sfwp_range u_range (
    .cfg  (cfg),
    .addr (addr_reg),
    .hit  (prot_hit)
  );

  function automatic logic is_array_write(input logic [7:0] op);
    is_array_write = (op == OP_PP) || (op == OP_SE) || (op == OP_BE32) || (op == OP_BE64);
  endfunction

  function automatic logic is_chip_erase(input logic [7:0] op);
    is_chip_erase = (op == OP_CE1) || (op == OP_CE2);
  endfunction

  logic [7:0] sh_in;
  logic       aligned, wr_ok, sr_locked, frozen, byte_done;
  logic [1:0] lock_mode;

  always_comb begin
    bit_next  = bit_reg;
    byte_next = byte_reg;
    sh_next   = sh_reg;
    op_next   = op_reg;
    addr_next = addr_reg;
    d1_next   = d1_reg;
    d2_next   = d2_reg;
    out_next  = out_reg;
    so_next   = so_reg;
    oe_next   = oe_reg;
    wel_next  = wel_reg;
    lklo_next = lklo_reg;
    lkhi_next = lkhi_reg;
    inv_next  = inv_reg;
    sec_next  = sec_reg;
    tb_next   = tb_reg;
    bp_next   = bp_reg;
    lb_next   = lb_reg;
    qe_next   = qe_reg;
    pwr_next  = pwr_reg;
    cmd_next  = '0;
    blk_next  = 1'b0;
    sh_in     = {sh_reg[6:0], si_sync_reg[1]};
    byte_done = sclk_rise && cs_low && (bit_reg == BIT_LAST);
    // byte boundary means no partial bits
    aligned   = (bit_reg == 3'h0);
    lock_mode = {lkhi_reg, lklo_reg};
    sr_locked = (lock_mode == 2'h1 && !wp_n) || lock_mode[1];
    frozen    = (lock_mode == 2'h1) && !wp_n;
    wr_ok     = wel_reg;

    // power cycle drops lock-down to 00
    if (power_up && lock_mode == 2'h2) begin
      lklo_next = 1'b0;
      lkhi_next = 1'b0;
    end

    if (!cs_low) begin
      bit_next  = 3'h0;
      byte_next = 9'h000;
      oe_next   = 1'b0;
    end else if (sclk_rise) begin
      bit_next = bit_reg + 3'h1;
      sh_next  = sh_in;
      if (byte_done) begin
        byte_next = byte_reg + 9'h001;
        if (byte_reg == 9'h000) begin
          op_next = sh_in;
          case (sh_in)
            OP_RDSR1: out_next = status1;
            OP_RDSR2: out_next = status2;
            OP_JEDEC: out_next = MFR_ID;
            default:  out_next = 8'h00;
          endcase
        end else if (byte_reg < BYTES_ADDR) begin
          addr_next = {addr_reg[15:0], sh_in};
          case (op_reg)
            OP_JEDEC: out_next = (byte_reg == 9'h001) ? TYPE_ID : CAP_ID;
            OP_RDSR1: out_next = status1;
            OP_RDSR2: out_next = status2;
            OP_MDID:  out_next = MFR_ID;
            OP_RDPD:  out_next = CAP_ID;
            default:  out_next = 8'h00;
          endcase
          if (byte_reg == 9'h001)
            d1_next = sh_in;
          if (byte_reg == 9'h002)
            d2_next = sh_in;
        end else begin
          case (op_reg)
            OP_MDID:  out_next = (byte_reg == BYTES_ADDR) ? CAP_ID : MFR_ID;
            OP_RDPD:  out_next = CAP_ID;
            OP_RDSR1: out_next = status1;
            OP_RDSR2: out_next = status2;
            default:  out_next = 8'h00;
          endcase
        end
      end
    end else if (sclk_fall && pwr_reg != SFWP_ST_DPD) begin
      // drive outputs until chip select rises
      if (bit_reg == 3'h0 && byte_reg != 9'h000) begin
        so_next  = out_reg[7];
        out_next = {out_reg[6:0], 1'b0};
        oe_next  = 1'b1;
      end else if (oe_reg) begin
        so_next  = out_reg[7];
        out_next = {out_reg[6:0], 1'b0};
      end
    end

    if (cs_rise && byte_reg != 9'h000) begin
      // only release works in deep power-down
      if (pwr_reg == SFWP_ST_DPD) begin
        if (op_reg == OP_RDPD)
          pwr_next = SFWP_ST_IDLE;
      end else if (!aligned) begin
        blk_next = 1'b1;
      end else begin
        case (op_reg)
          OP_WREN: wel_next = 1'b1;
          OP_WRDI: wel_next = 1'b0;
          OP_DPD:  pwr_next = SFWP_ST_DPD;
          OP_WRSR: begin
            if (wr_ok && !sr_locked && byte_reg >= BYTES_SR1) begin
              wel_next = 1'b0;
              if (!frozen) begin
                lklo_next = d1_reg[SR1_LKLO];
                sec_next  = d1_reg[SR1_SEC];
                tb_next   = d1_reg[SR1_SEC-1];
                bp_next   = d1_reg[SR1_BP0+2:SR1_BP0];
              end
              if (byte_reg >= BYTES_WRSR) begin
                inv_next = d2_reg[SR2_INV];
                qe_next  = d2_reg[1];
                lb_next  = lb_reg | d2_reg[5:3];
                if (!frozen)
                  lkhi_next = d2_reg[SR2_LKHI];
              end
            end else begin
              blk_next = 1'b1;
            end
          end
          OP_ERSEC, OP_PGSEC: begin
            if (wr_ok) begin
              wel_next = 1'b0;
              cmd_next = '{valid: 1'b1, opcode: op_reg, addr: addr_reg};
            end else begin
              blk_next = 1'b1;
            end
          end
          default: begin
            if (is_array_write(op_reg) || is_chip_erase(op_reg)) begin
              if (wr_ok && byte_reg >= (is_chip_erase(op_reg) ? BYTES_ONE : BYTES_ADDR) &&
                  !(is_chip_erase(op_reg) ? (cfg.protect_size != 3'h0 || cfg.invert_protect_map) : prot_hit)) begin
                wel_next = 1'b0;
                cmd_next = '{valid: 1'b1, opcode: op_reg, addr: addr_reg};
              end else begin
                blk_next = 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_reg  <= 3'h0;
      byte_reg <= 9'h000;
      sh_reg   <= 8'h00;
      op_reg   <= 8'h00;
      addr_reg <= 24'h000000;
      d1_reg   <= 8'h00;
      d2_reg   <= 8'h00;
      out_reg  <= 8'h00;
      so_reg   <= 1'b0;
      oe_reg   <= 1'b0;
      wel_reg  <= 1'b0;
      lklo_reg <= 1'b0;
      lkhi_reg <= 1'b0;
      inv_reg  <= 1'b0;
      sec_reg  <= 1'b0;
      tb_reg   <= 1'b0;
      bp_reg   <= 3'h0;
      lb_reg   <= 3'h0;
      qe_reg   <= 1'b0;
      pwr_reg  <= SFWP_ST_IDLE;
      cmd_reg  <= '0;
      blk_reg  <= 1'b0;
    end else begin
      bit_reg  <= bit_next;
      byte_reg <= byte_next;
      sh_reg   <= sh_next;
      op_reg   <= op_next;
      addr_reg <= addr_next;
      d1_reg   <= d1_next;
      d2_reg   <= d2_next;
      out_reg  <= out_next;
      so_reg   <= so_next;
      oe_reg   <= oe_next;
      wel_reg  <= wel_next;
      lklo_reg <= lklo_next;
      lkhi_reg <= lkhi_next;
      inv_reg  <= inv_next;
      sec_reg  <= sec_next;
      tb_reg   <= tb_next;
      bp_reg   <= bp_next;
      lb_reg   <= lb_next;
      qe_reg   <= qe_next;
      pwr_reg  <= pwr_next;
      cmd_reg  <= cmd_next;
      blk_reg  <= blk_next;
    end
  end

  assign so              = so_reg;
  assign so_oe           = oe_reg;
  assign status1         = {lklo_reg, sec_reg, tb_reg, bp_reg, wel_reg, 1'b0};
  assign status2         = {1'b0, inv_reg, lb_reg, 1'b0, qe_reg, lkhi_reg};
  assign deep_power_down = (pwr_reg == SFWP_ST_DPD);
  assign exec_cmd        = cmd_reg;
  assign exec_blocked    = blk_reg;

endmodule

// ---- rtl/sfwp_pkg.sv ----
// package for the serial flash write-protect block
// assumes a 1MB array, 24-bit addresses on the link
package sfwp_pkg;

  localparam int          ADDR_W      = 24;
  localparam logic [23:0] ARRAY_TOP   = 24'h0FFFFF;
  localparam logic [23:0] ADDR_MASK   = 24'h0FFFFF;
  localparam int          BLK_SHIFT   = 16;
  localparam int          SEC_SHIFT   = 12;
  localparam logic [2:0]  BIT_LAST    = 3'h7;

  // opcodes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE32  = 8'h52;
  localparam logic [7:0] OP_BE64  = 8'hD8;
  localparam logic [7:0] OP_CE1   = 8'hC7;
  localparam logic [7:0] OP_CE2   = 8'h60;
  localparam logic [7:0] OP_ERSEC = 8'h44;
  localparam logic [7:0] OP_PGSEC = 8'h42;
  localparam logic [7:0] OP_DPD   = 8'hB9;
  localparam logic [7:0] OP_RDPD  = 8'hAB;
  localparam logic [7:0] OP_MDID  = 8'h90;
  localparam logic [7:0] OP_JEDEC = 8'h9F;

  // status register 1 bit positions
  localparam int SR1_WIP  = 0;
  localparam int SR1_WEL  = 1;
  localparam int SR1_BP0  = 2;
  localparam int SR1_SEC  = 6;
  localparam int SR1_LKLO = 7;
  // status register 2 bit positions
  localparam int SR2_LKHI = 0;
  localparam int SR2_INV  = 6;

  // byte counts at which an instruction is complete
  localparam logic [8:0] BYTES_ADDR = 9'h004;
  localparam logic [8:0] BYTES_WRSR = 9'h003;
  localparam logic [8:0] BYTES_ONE  = 9'h001;
  localparam logic [8:0] BYTES_SR1  = 9'h002;

  typedef struct packed {
    logic       status_lock_mode_hi;
    logic       status_lock_mode_lo;
    logic       invert_protect_map;
    logic       small_unit_select;
    logic       bottup_dummy;
  } sfwp_unused_t;

  typedef struct packed {
    logic       invert_protect_map;
    logic       small_unit_select;
    logic       bottom_up_select;
    logic [2:0] protect_size;
  } sfwp_prot_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [23:0] addr;
  } sfwp_cmd_t;

  typedef enum logic [1:0] {
    SFWP_ST_IDLE   = 2'b00,
    SFWP_ST_ACTIVE = 2'b01,
    SFWP_ST_DPD    = 2'b10
  } sfwp_pwr_t;

  localparam logic [7:0] MFR_ID_DEF  = 8'hA5;
  localparam logic [7:0] TYPE_ID_DEF = 8'h5A;
  localparam logic [7:0] CAP_ID_DEF  = 8'h3C;

endpackage

// ---- rtl/sfwp_range.sv ----
// protected address range decode from the block-protect fields
// pure combinational; caller registers the result if needed
`timescale 1ns/1ps
module sfwp_range
  import sfwp_pkg::*;
(
  input  wire sfwp_prot_cfg_t cfg,
  input  wire logic [23:0]    addr,
  output logic                hit
);

  logic [23:0] span;
  logic        none;
  logic        all;
  logic        in_low;
  logic        in_high;
  logic        base_hit;
  logic [23:0] a;

  always_comb begin
    a        = addr & ADDR_MASK;
    span     = 24'h000000;
    none     = 1'b0;
    all      = 1'b0;
    if (cfg.protect_size == 3'h0) begin
      none = 1'b1;
    end else if (cfg.protect_size[2:1] == 2'h3 ||
                 (cfg.protect_size == 3'h5 && !cfg.small_unit_select)) begin
      all = 1'b1;
    end else if (cfg.small_unit_select) begin
      if (cfg.protect_size[2])
        span = 24'h008000;
      else
        span = 24'(1) << (SEC_SHIFT + int'(cfg.protect_size) - 1);
    end else begin
      span = 24'(1) << (BLK_SHIFT + int'(cfg.protect_size) - 1);
    end
    in_low  = a < span;
    in_high = a > (ARRAY_TOP - span);
    base_hit = all || (!none && (cfg.bottom_up_select ? in_low : in_high));
    hit = cfg.invert_protect_map ? !base_hit : base_hit;
  end

endmodule

// ---- testbench/sfwp_core_monitor.sv ----
// port checker for the write-protect block
// assumes a bind onto sfwp_core, one ref_clk domain
`timescale 1ns/1ps
module sfwp_core_monitor
  import sfwp_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       power_up,
  input wire logic       sclk,
  input wire logic       cs_b,
  input wire logic       si,
  input wire logic       wp_b,
  input wire logic       so,
  input wire logic       so_oe,
  input wire logic [7:0] status1,
  input wire logic [7:0] status2,
  input wire logic       deep_power_down,
  input wire sfwp_cmd_t  exec_cmd,
  input wire logic       exec_blocked
);
  logic [2:0] wp_low_reg;
  logic [2:0] wp_low_next;
  logic       mode_hw;
  logic       mode_psl;
  logic       mode_otp;
  assign mode_hw  = status1[SR1_LKLO] & ~status2[SR2_LKHI];
  assign mode_psl = ~status1[SR1_LKLO] & status2[SR2_LKHI];
  assign mode_otp = status1[SR1_LKLO] & status2[SR2_LKHI];
  // cycles the protect pin has been low, saturating
  always_comb begin
    wp_low_next = wp_b ? 3'h0 : ((wp_low_reg == 3'h7) ? 3'h7 : wp_low_reg + 3'h1);
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) wp_low_reg <= 3'h0;
    else wp_low_reg <= wp_low_next;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_exec_needs_latch:
    assert property (exec_cmd.valid |-> $past(status1[SR1_WEL])) else $error("write op ran without latch");
  a_exec_clears_latch:
    assert property (exec_cmd.valid |-> !status1[SR1_WEL]) else $error("latch left set after write op");
  a_pulse_exclusive:
    assert property (exec_cmd.valid |-> !exec_blocked ##1 !exec_cmd.valid) else $error("exec pulse malformed");
  a_dpd_quiet:
    assert property (deep_power_down && $past(deep_power_down) |-> !exec_cmd.valid && !exec_blocked
      && $stable(status1)) else $error("instruction acted in deep power-down");
  a_otp_frozen:
    assert property (mode_otp |=> $stable(status1[7:2]) && $stable(status2[SR2_LKHI]))
      else $error("status changed in one-time lock");
  a_lockdown_held:
    assert property (mode_psl && !power_up && !$past(power_up) |=> $stable(status1[7:2]))
      else $error("status changed in supply lock-down");
  a_power_unlock:
    assert property (mode_psl && power_up |-> ##[1:2] !status2[SR2_LKHI]) else $error("power cycle kept lock");
  a_hw_freeze:
    assert property (mode_hw && wp_low_reg >= 3'h5 |=> $stable(status1[7:2]) && $stable(status2[SR2_LKHI]))
      else $error("protect bits changed with pin low");
  a_so_release:
    assert property ($rose(cs_b) |-> ##[1:6] !so_oe) else $error("output still driven after deselect");
  c_exec: cover property (exec_cmd.valid);
  c_blocked_locked: cover property (exec_blocked && status1[SR1_LKLO]);
  c_dpd: cover property ($rose(deep_power_down));
endmodule
bind sfwp_core sfwp_core_monitor u_sfwp_core_monitor (
  .ref_clk(ref_clk), .rst_b(rst_b), .power_up(power_up), .sclk(sclk), .cs_b(cs_b), .si(si),
  .wp_b(wp_b), .so(so), .so_oe(so_oe), .status1(status1), .status2(status2),
  .deep_power_down(deep_power_down), .exec_cmd(exec_cmd), .exec_blocked(exec_blocked));

// ---- testbench/sfwp_core_tb_top.sv ----
// self-checking bench for the write-protect block
// assumes the host model drives the link pins
`timescale 1ns/1ps
module sfwp_core_tb_top;
  import sfwp_pkg::*;
  logic        ref_clk, rst_b, power_up, wp_b, so, so_oe, deep_power_down, exec_blocked, sclk, cs_b, si;
  logic [7:0]  status1, status2;
  logic [23:0] last_addr;
  logic [7:0]  last_op;
  sfwp_cmd_t   exec_cmd;
  int          fails, samples_checked, n_exec, n_blk;
  localparam logic [47:0] RANGE_TBL [17] = '{
    48'h00_00_0FFFFF_00, 48'h04_00_0F0000_01, 48'h04_00_0EFFFF_00, 48'h30_00_07FFFF_01,
    48'h30_00_080000_00, 48'h34_00_0FFFFF_01, 48'h58_00_07FFFF_01, 48'h44_00_0FF000_01,
    48'h44_00_0FEFFF_00, 48'h54_00_0F8000_01, 48'h54_00_0F7FFF_00, 48'h68_00_001FFF_01,
    48'h68_00_002000_00, 48'h04_40_0F0000_00, 48'h04_40_0EFFFF_01, 48'h00_40_0FFFFF_01,
    48'h1C_40_000000_00};
  sfwp_core u_sfwp_core (.ref_clk(ref_clk), .rst_b(rst_b), .power_up(power_up), .sclk(sclk),
    .cs_b(cs_b), .si(si), .wp_b(wp_b), .so(so), .so_oe(so_oe), .status1(status1), .status2(status2),
    .deep_power_down(deep_power_down), .exec_cmd(exec_cmd), .exec_blocked(exec_blocked));
  sfwp_host u_sfwp_host (.sclk(sclk), .cs_b(cs_b), .si(si), .so(so));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // mid-cycle sampling keeps clear of the launching edge
  always @(negedge ref_clk) begin
    if (exec_cmd.valid === 1'b1) begin
      n_exec++;
      last_addr = exec_cmd.addr;
      last_op   = exec_cmd.opcode;
    end
    if (exec_blocked === 1'b1) n_blk++;
  end
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic go(input logic [7:0] tx[$], input int cut = 0);
    @(posedge ref_clk);
    #1;
    u_sfwp_host.frame(tx, cut);
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic wr_sr(input logic [7:0] s1, input logic [7:0] s2);
    go({OP_WREN});
    go({OP_WRSR, s1, s2});
  endtask
  task automatic pulse_power;
    @(posedge ref_clk);
    #1 power_up = 1'b1;
    @(posedge ref_clk);
    #1 power_up = 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic t_range;
    logic [47:0] r;
    int e, b;
    foreach (RANGE_TBL[i]) begin
      r = RANGE_TBL[i];
      wr_sr(r[47:40], r[39:32]);
      chk("protect_fields", 24'(r[46:42]), 24'(status1[6:2]));
      chk("invert_bit", 24'(r[38]), 24'(status2[SR2_INV]));
      e = n_exec;
      b = n_blk;
      go({OP_WREN});
      go({OP_PP, r[31:24], r[23:16], r[15:8], 8'h3C});
      chk("pp_exec", 24'(!r[0]), 24'(n_exec - e));
      chk("pp_block", 24'(r[0]), 24'(n_blk - b));
      if (!r[0]) chk("pp_addr", r[31:8], last_addr);
      if (!r[0]) chk("pp_op", 24'(OP_PP), 24'(last_op));
    end
    $display("test range done");
  endtask
  task automatic t_frame;
    int e, b;
    wr_sr(8'h00, 8'h00);
    e = n_exec;
    b = n_blk;
    go({OP_WREN, 8'hFF}, 5);
    chk("latch_misaligned", 24'h0, 24'(status1[SR1_WEL]));
    chk("block_misaligned", 24'h1, 24'(n_blk - b));
    go({OP_WREN});
    chk("latch_set", 24'h1, 24'(status1[SR1_WEL]));
    go({OP_PP, 8'h00, 8'h10, 8'h00, 8'hA5, 8'hFF}, 4);
    chk("latch_kept", 24'h1, 24'(status1[SR1_WEL]));
    go({OP_WRDI});
    b = n_blk;
    go({OP_WRSR, 8'h10, 8'h00});
    go({OP_SE, 8'h00, 8'h10, 8'h00});
    chk("no_latch_block", 24'h2, 24'(n_blk - b));
    chk("no_latch_exec", 24'(e), 24'(n_exec));
    chk("size_kept", 24'h0, 24'(status1[4:2]));
    $display("test frame done");
  endtask
  task automatic t_locks;
    int b;
    wr_sr(8'h80, 8'h00);
    #1 wp_b = 1'b0;
    b = n_blk;
    wr_sr(8'h84, 8'h01);
    chk("hw_locked", 24'h20, 24'(status1[7:2]));
    chk("hw_block", 24'h1, 24'(n_blk - b));
    #1 wp_b = 1'b1;
    wr_sr(8'h00, 8'h01);
    chk("unlocked_write", 24'h1, 24'(status2[SR2_LKHI]));
    wr_sr(8'h04, 8'h00);
    chk("psl_locked", 24'h8, 24'({status2[SR2_LKHI], status1[4:2]}));
    pulse_power;
    chk("psl_released", 24'h0, 24'({status2[SR2_LKHI], status1[SR1_LKLO]}));
    $display("test locks done");
  endtask
  task automatic t_dpd;
    go({OP_WRDI});
    go({OP_DPD});
    chk("dpd_entered", 24'h1, 24'(deep_power_down));
    go({OP_WREN});
    chk("dpd_ignored", 24'h0, 24'(status1[SR1_WEL]));
    go({OP_RDPD});
    chk("dpd_left", 24'h0, 24'(deep_power_down));
    $display("test dpd done");
  endtask
  task automatic t_ids;
    go({OP_JEDEC, 8'h00, 8'h00, 8'h00});
    chk("jedec", {MFR_ID_DEF, TYPE_ID_DEF, CAP_ID_DEF}, {u_sfwp_host.rx_q[1], u_sfwp_host.rx_q[2],
      u_sfwp_host.rx_q[3]});
    go({OP_MDID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("mfr_dev", 24'({MFR_ID_DEF, CAP_ID_DEF}), 24'({u_sfwp_host.rx_q[4], u_sfwp_host.rx_q[5]}));
    go({OP_RDPD, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("cap_id", 24'(CAP_ID_DEF), 24'(u_sfwp_host.rx_q[4]));
    go({OP_WREN});
    go({OP_RDSR1, 8'h00});
    chk("sr1_read", 24'h02, 24'(u_sfwp_host.rx_q[1]));
    $display("test ids done");
  endtask
  task automatic t_erase;
    int e, b;
    e = n_exec;
    b = n_blk;
    go({OP_WREN});
    go({OP_CE1});
    chk("ce_op", 24'(OP_CE1), 24'(last_op));
    wr_sr(8'h04, 8'h00);
    go({OP_WREN});
    go({OP_CE2});
    go({OP_BE64, 8'h0F, 8'h00, 8'h00});
    go({OP_BE32, 8'h00, 8'h00, 8'h00});
    chk("be_op", 24'(OP_BE32), 24'(last_op));
    go({OP_ERSEC, 8'h00, 8'h10, 8'h00});
    go({OP_WREN});
    go({OP_PGSEC, 8'h00, 8'h10, 8'h00, 8'hAA});
    chk("sec_op", 24'(OP_PGSEC), 24'(last_op));
    chk("erase_exec", 24'h3, 24'(n_exec - e));
    chk("erase_block", 24'h3, 24'(n_blk - b));
    wr_sr(8'h00, 8'h02);
    go({OP_RDSR2, 8'h00});
    chk("sr2_read", 24'h02, 24'(u_sfwp_host.rx_q[1]));
    $display("test erase done");
  endtask
  task automatic t_otp;
    int b;
    wr_sr(8'h80, 8'h01);
    b = n_blk;
    wr_sr(8'h00, 8'h00);
    pulse_power;
    chk("otp_kept", 24'h3, 24'({status1[SR1_LKLO], status2[SR2_LKHI]}));
    chk("otp_block", 24'h1, 24'(n_blk - b));
    $display("test otp done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #900000;
    fails++;
    report_and_stop;
  end
  initial begin
    rst_b = 1'b0;
    power_up = 1'b0;
    wp_b = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    repeat (5) @(posedge ref_clk);
    t_range;
    t_frame;
    t_locks;
    t_dpd;
    t_ids;
    t_erase;
    t_otp;
    report_and_stop;
  end
endmodule

// ---- testbench/sfwp_host.sv ----
// host controller model on the serial link
// assumes one instruction per frame call
`timescale 1ns/1ps
module sfwp_host (
  output logic     sclk,
  output logic     cs_b,
  output logic     si,
  input wire logic so
);
  logic [7:0] rx_q[$];
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    si   = 1'b0;
  end
  task automatic frame(input logic [7:0] tx[$], input int cut);
    int n;
    n = tx.size() * 8 - cut;
    rx_q = {};
    cs_b = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = tx[i / 8][7 - i % 8];
      #80 sclk = 1'b1;
      if (i % 8 == 0) rx_q.push_back(8'h00);
      rx_q[i / 8] = {rx_q[i / 8][6:0], so};
      #80 sclk = 1'b0;
    end
    #80 cs_b = 1'b1;
    si = ~si;
  endtask
endmodule
